//--- legacy_io_space_controls_tb.sv
`default_nettype none
module legacy_io_space_controls_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lio_pkg::*;
  logic clk, rst_b, rd, wr, ack, clr_s, clr_b, rst_out_b, ssc_s, ssc_b, shut, halt, nmi, bad;
  logic [31:0] addr, wdata, rdata, q;
  lio_cyc_s cyc;
  lio_dec_s dec;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] bases [4] = '{LIO_BASE_100, LIO_BASE_101, LIO_BASE_110, LIO_BASE_111};
  lio_legacy_io_controls uut (.i_clk(clk), .i_rst_b(rst_b), .i_msr_rd(rd), .i_msr_wr(wr), .i_msr_addr(addr),
    .i_msr_wdata(wdata), .o_msr_rdata(rdata), .o_msr_ack(ack), .i_cyc(cyc), .o_dec(dec), .i_bad_txn(bad),
    .i_ssc_clr_shut(clr_s), .i_ssc_clr_bad(clr_b), .o_reset_out_b(rst_out_b), .o_ssc_shutdown(ssc_s),
    .o_ssc_bad(ssc_b), .o_shutdown(shut), .o_halt(halt), .o_nmi_en(nmi));
  lio_bus_master m (.i_clk(clk), .o_cyc(cyc), .o_bad(bad));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tchk(input lio_tgt_e e);
    chk("target", {29'h0, e}, {29'h0, dec.target});
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
    q = rdata;
  endtask
  task automatic setc(input logic [31:0] v);
    acc(1'b1, LIO_CTL_ADDR, v & 32'hdfff_ffff);
  endtask
  task automatic io(input logic w, input logic [15:0] p, input logic [7:0] d);
    m.issue({2'b01, 1'b0, w, 2'b00}, {16'h0, p}, d);
  endtask
  task automatic t_regs;
    acc(1'b0, LIO_CTL_ADDR, 0);
    chk("ctl reset", LIO_CTL_RESET, q);
    setc(32'hd088_fffc);
    acc(1'b1, LIO_CTL_ADDR + 1, 32'hffff_ffff);
    acc(1'b0, LIO_CTL_ADDR, 0);
    chk("ctl rsvd", 32'hd088_fffc, q);
    acc(1'b0, LIO_CTL_ADDR + 1, 0);
    chk("unmapped", 32'h0, q);
    @(negedge clk);
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    acc(1'b0, LIO_CTL_ADDR, 0);
    chk("ctl rerst", LIO_CTL_RESET, q);
    m.issue(6'b100000, 32'h000f_0020, 0);
    chk("remap f dflt", 32'hffff_0020, dec.addr);
    io(1'b0, 16'h0071, 0);
    tchk(LIO_TGT_RTC);
  endtask
  task automatic t_special;
    setc(32'h8000_0000);
    m.issue(6'b001000, 32'h0, 0);
    chk("shut", 32'h1, {31'h0, shut});
    chk("rst out", 32'h0, {31'h0, rst_out_b});
    chk("ssc shut", 32'h1, {31'h0, ssc_s});
    repeat (LIO_RST_OUT_CYC - 1) @(negedge clk);
    chk("rst width", 32'h0, {31'h0, rst_out_b});
    @(negedge clk);
    chk("rst end", 32'h1, {31'h0, rst_out_b});
    clr_s = 1'b1;
    @(negedge clk);
    clr_s = 1'b0;
    @(negedge clk);
    chk("ssc clr", 32'h0, {31'h0, ssc_s});
    for (int md = 0; md < 2; md++) begin
      setc(32'(md) << LIO_SPEC_MD_BIT);
      for (int c = 0; c < 4; c++) begin
        m.issue(6'b001000, 32'(c), 0);
        chk("halt", 32'(c == (md ? 2 : 1)), {31'h0, halt});
        chk("shut", 32'(c == 0), {31'h0, shut});
        chk("no rst", 32'h1, {31'h0, rst_out_b});
      end
    end
  endtask
  task automatic t_bad;
    setc(32'h4000_0000);
    m.pulse_bad();
    chk("bad rst", 32'h0, {31'h0, rst_out_b});
    chk("ssc bad", 32'h1, {31'h0, ssc_b});
    setc(32'h0);
    repeat (LIO_RST_OUT_CYC) @(negedge clk);
    clr_b = 1'b1;
    @(negedge clk);
    clr_b = 1'b0;
    m.pulse_bad();
    chk("bad off", 32'h1, {31'h0, rst_out_b});
    chk("ssc off", 32'h0, {31'h0, ssc_b});
  endtask
  task automatic t_mem;
    setc(32'h0c00_0000);
    m.issue(6'b100000, 32'h000e_1234, 0);
    chk("remap e", 32'hfffe_1234, dec.addr);
    chk("dec kind", 32'h3, {30'h0, dec.valid, dec.is_mem});
    @(negedge clk);
    chk("dec idle", 32'h0, {31'h0, dec.valid});
    m.issue(6'b100000, 32'h000f_0010, 0);
    chk("remap f", 32'hffff_0010, dec.addr);
    m.issue(6'b100010, 32'h000e_1234, 0);
    chk("dedicated", 32'h000e_1234, dec.addr);
    setc(32'h0200_0000);
    m.issue(6'b100000, 32'h000e_5678, 0);
    chk("no remap", 32'h000e_5678, dec.addr);
    tchk(LIO_TGT_DISCARD);
    chk("ones", 32'h1, {31'h0, dec.rd_ones});
    m.issue(6'b100100, 32'h0010_0000, 8'h5a);
    tchk(LIO_TGT_DISCARD);
    chk("wr ones", 32'h0, {31'h0, dec.rd_ones});
    m.issue(6'b100001, 32'h0010_0000, 0);
    tchk(LIO_TGT_ONCHIP);
    setc(32'h0);
    m.issue(6'b100100, 32'h0010_0000, 8'h5a);
    tchk(LIO_TGT_LPC);
  endtask
  task automatic t_io;
    for (int u = 0; u < 2; u++) begin
      for (int s = 0; s < 8; s++) begin
        setc(32'(s) << (u ? LIO_UART2_LSB : LIO_UART1_LSB));
        for (int b = 0; b < 4; b++) begin
          io(1'b0, bases[b], 0);
          tchk((s >= 4 && b == s % 4) ? (u ? LIO_TGT_UART2 : LIO_TGT_UART1) : LIO_TGT_LPC);
        end
      end
    end
    setc(32'h0177_0000);
    io(1'b0, LIO_BASE_111, 0);
    tchk(LIO_TGT_ERROR);
    io(1'b0, 16'h0100, 0);
    tchk(LIO_TGT_DISCARD);
    chk("io ones", 32'h1, {31'h0, dec.rd_ones});
    setc(32'h0000_0002);
    io(1'b0, 16'h0073, 0);
    tchk(LIO_TGT_RTC);
    io(1'b0, 16'h0071, 0);
    tchk(LIO_TGT_LPC);
    io(1'b1, LIO_PORT_RTC_IDX, 8'h80);
    tchk(LIO_TGT_RTC);
    chk("nmi", 32'h1, {31'h0, nmi});
    setc(32'h0);
    io(1'b0, 16'h0072, 0);
    tchk(LIO_TGT_LPC);
  endtask
  task automatic close_out;
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    {rd, wr, clr_s, clr_b} = 4'h0;
    addr = 32'h0;
    wdata = 32'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    t_special();
    t_bad();
    t_mem();
    t_io();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire

//--- lio_bus_master.sv
`default_nettype none
module lio_bus_master (
  input wire logic i_clk, // system clock
  output lio_pkg::lio_cyc_s o_cyc, // cycle toward the block
  output logic o_bad // bad transaction pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import lio_pkg::*;
  initial begin
    o_cyc = '0;
    o_bad = 1'b0;
  end
  // kind = {is_mem, is_io, is_special, write, dedicated, claimed}
  task automatic issue(input logic [5:0] kind, input logic [31:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_cyc = {1'b1, kind, a, d};
    @(negedge i_clk);
    // released bus shows no stale cycle
    o_cyc = {1'b0, ~o_cyc[45:0]};
  endtask
  task automatic pulse_bad;
    @(negedge i_clk);
    o_bad = 1'b1;
    @(negedge i_clk);
    o_bad = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- lio_legacy_io_controls.sv
`default_nettype none
module lio_legacy_io_controls (
  input wire logic i_clk, // 200 MHz system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_msr_rd, // register read strobe
  input wire logic i_msr_wr, // register write strobe
  input wire logic [31:0] i_msr_addr, // register address
  input wire logic [31:0] i_msr_wdata, // register write data
  output logic [31:0] o_msr_rdata, // register read data
  output logic o_msr_ack, // access done pulse
  input wire lio_pkg::lio_cyc_s i_cyc, // cycle from bus master
  output lio_pkg::lio_dec_s o_dec, // decode answer
  input wire logic i_bad_txn, // bad transaction seen
  input wire logic i_ssc_clr_shut, // clear shutdown reason
  input wire logic i_ssc_clr_bad, // clear bad reason
  output logic o_reset_out_b, // system reset out, low active
  output logic o_ssc_shutdown, // reason bit 9 of 54h
  output logic o_ssc_bad, // reason bit 12 of 54h
  output logic o_shutdown, // shutdown cycle seen pulse
  output logic o_halt, // halt cycle seen pulse
  output logic o_nmi_en // nmi enable state
);
  import lio_pkg::*;

  logic [31:0] ctl_q;
  logic [7:0] rst_cnt_q;
  logic [7:0] rst_cnt_d;
  logic written_q;
  logic sc_hit, sc_shut, sc_halt, shut_rst, bad_rst;
  logic [15:0] io_a;
  logic [15:0] u1_base, u2_base;
  logic u1_on, u2_on, u1_hit, u2_hit;
  logic u_clash;
  logic rtc_idx_hit, rtc_hi_hit;
  lio_dec_s dec_d;

  function automatic logic [15:0] uart_base(input logic [1:0] sel);
    case (sel)
      2'b00: uart_base = LIO_BASE_100;
      2'b01: uart_base = LIO_BASE_101;
      2'b10: uart_base = LIO_BASE_110;
      default: uart_base = LIO_BASE_111;
    endcase
  endfunction

  // control register; reserved bits held as written
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_q <= LIO_CTL_RESET;
      written_q <= 1'b0;
    end else if (i_msr_wr && i_msr_addr == LIO_CTL_ADDR) begin
      ctl_q <= i_msr_wdata;
      written_q <= 1'b1;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_msr_rdata <= 32'h0000_0000;
      o_msr_ack <= 1'b0;
    end else begin
      o_msr_ack <= i_msr_rd | i_msr_wr;
      o_msr_rdata <= (i_msr_rd && i_msr_addr == LIO_CTL_ADDR) ? ctl_q : 32'h0000_0000;
    end
  end

  // special cycle code is the low address byte
  always_comb begin
    sc_hit = i_cyc.valid & i_cyc.is_special;
    sc_shut = sc_hit & (i_cyc.addr[7:0] == LIO_SC_SHUTDOWN);
    sc_halt = sc_hit & (ctl_q[LIO_SPEC_MD_BIT] ? (i_cyc.addr[7:0] == LIO_SC_HALT_X86)
                                                : (i_cyc.addr[7:0] == LIO_SC_HALT_BUS));
    shut_rst = sc_shut & ctl_q[LIO_SHUT_EN_BIT];
    bad_rst = i_bad_txn & ctl_q[LIO_BAD_EN_BIT];
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_shutdown <= 1'b0;
      o_halt <= 1'b0;
    end else begin
      o_shutdown <= sc_shut;
      o_halt <= sc_halt;
    end
  end

  // retrigger restarts the full pulse width
  always_comb begin
    if (shut_rst || bad_rst) begin
      rst_cnt_d = 8'(LIO_RST_OUT_CYC);
    end else if (rst_cnt_q != 8'h00) begin
      rst_cnt_d = rst_cnt_q - 8'h01;
    end else begin
      rst_cnt_d = 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_cnt_q <= 8'h00;
      o_reset_out_b <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      o_reset_out_b <= (rst_cnt_d == 8'h00);
    end
  end

  // reason flags: a new cause beats a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ssc_shutdown <= 1'b0;
      o_ssc_bad <= 1'b0;
    end else begin
      if (shut_rst) begin
        o_ssc_shutdown <= 1'b1;
      end else if (i_ssc_clr_shut) begin
        o_ssc_shutdown <= 1'b0;
      end
      if (bad_rst) begin
        o_ssc_bad <= 1'b1;
      end else if (i_ssc_clr_bad) begin
        o_ssc_bad <= 1'b0;
      end
    end
  end

  // i/o side decode
  always_comb begin
    io_a = i_cyc.addr[15:0];
    u1_on = ctl_q[LIO_UART1_LSB + 2];
    u2_on = ctl_q[LIO_UART2_LSB + 2];
    u1_base = uart_base(ctl_q[LIO_UART1_LSB +: 2]);
    u2_base = uart_base(ctl_q[LIO_UART2_LSB +: 2]);
    u1_hit = u1_on & (io_a[15:3] == u1_base[15:3]);
    u2_hit = u2_on & (io_a[15:3] == u2_base[15:3]);
    u_clash = u1_on & u2_on & (u1_base == u2_base);
    rtc_idx_hit = io_a[15:1] == LIO_PORT_RTC_IDX[15:1];
    rtc_hi_hit = io_a[15:1] == LIO_PORT_RTC_HI[15:1];
  end

  always_comb begin
    dec_d = '0;
    dec_d.valid = i_cyc.valid;
    dec_d.is_mem = i_cyc.is_mem;
    dec_d.addr = i_cyc.addr;
    dec_d.target = LIO_TGT_LPC;
    if (i_cyc.is_special) begin
      dec_d.target = LIO_TGT_SPECIAL;
    end else if (i_cyc.is_mem) begin
      // dedicated comparators see the address unremapped
      if (!i_cyc.dedicated && ctl_q[LIO_REMAP_E_BIT] && i_cyc.addr[31:16] == LIO_SEG_E) begin
        dec_d.addr[31:16] = LIO_TOP_E;
      end else if (!i_cyc.dedicated && ctl_q[LIO_REMAP_F_BIT] && i_cyc.addr[31:16] == LIO_SEG_F) begin
        dec_d.addr[31:16] = LIO_TOP_F;
      end
      if (i_cyc.claimed) begin
        dec_d.target = LIO_TGT_ONCHIP;
      end else if (ctl_q[LIO_MEM_DISCARD_BIT]) begin
        dec_d.target = LIO_TGT_DISCARD;
      end
    end else if (i_cyc.is_io) begin
      if (rtc_idx_hit && ((i_cyc.write && !io_a[0]) || ctl_q[LIO_RTC_IDX_BIT])) begin
        dec_d.target = LIO_TGT_RTC;
      end else if (rtc_hi_hit && ctl_q[LIO_RTC_HI_BIT]) begin
        dec_d.target = LIO_TGT_RTC;
      end else if (u1_hit && u2_hit) begin
        dec_d.target = LIO_TGT_ERROR;
      end else if (u1_hit) begin
        dec_d.target = LIO_TGT_UART1;
      end else if (u2_hit) begin
        dec_d.target = LIO_TGT_UART2;
      end else if (i_cyc.claimed) begin
        dec_d.target = LIO_TGT_ONCHIP;
      end else if (ctl_q[LIO_IO_DISCARD_BIT]) begin
        dec_d.target = LIO_TGT_DISCARD;
      end
    end
    dec_d.rd_ones = (dec_d.target == LIO_TGT_DISCARD) & ~i_cyc.write;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dec <= '0;
    end else begin
      o_dec <= dec_d;
    end
  end

  // index port data bit 7 sets nmi enable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_nmi_en <= 1'b0;
    end else if (i_cyc.valid && i_cyc.is_io && i_cyc.write && io_a == LIO_PORT_RTC_IDX) begin
      o_nmi_en <= i_cyc.wdata[7];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_shut_cyc;
    sc_hit && i_cyc.addr[7:0] == 8'h00;
  endsequence
  sequence s_reset_low;
    !o_reset_out_b && o_shutdown;
  endsequence

  property p_reset_value;
    !written_q |-> ctl_q == 32'h0400_0003;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("control reset value wrong");

  property p_shut_reset;
    s_shut_cyc ##0 ctl_q[31] |=> s_reset_low ##0 o_ssc_shutdown;
  endproperty
  a_shut_reset: assert property (p_shut_reset) else $error("shutdown did not reset");

  property p_no_reset;
    !ctl_q[31] && !ctl_q[30] && rst_cnt_q == 8'h00 |=> o_reset_out_b;
  endproperty
  a_no_reset: assert property (p_no_reset) else $error("reset issued while disabled");

  property p_reset_width;
    $fell(o_reset_out_b) |-> !o_reset_out_b [*8];
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("reset pulse too short");

  property p_bad_reset;
    i_bad_txn && ctl_q[30] |=> !o_reset_out_b && o_ssc_bad;
  endproperty
  a_bad_reset: assert property (p_bad_reset) else $error("bad transaction did not reset");

  property p_halt_code;
    sc_hit && i_cyc.addr[7:0] == (ctl_q[28] ? 8'h02 : 8'h01) |=> o_halt && !o_shutdown;
  endproperty
  a_halt_code: assert property (p_halt_code) else $error("halt not decoded");

  property p_ignored_code;
    sc_hit && i_cyc.addr[7:0] > 8'h02 |=> !o_halt && !o_shutdown;
  endproperty
  a_ignored_code: assert property (p_ignored_code) else $error("unknown special code acted on");

  property p_remap_e;
    i_cyc.valid && i_cyc.is_mem && !i_cyc.is_special && !i_cyc.dedicated && ctl_q[27] &&
      i_cyc.addr[31:16] == 16'h000e |=> o_dec.addr[31:16] == 16'hfffe;
  endproperty
  a_remap_e: assert property (p_remap_e) else $error("e segment not remapped");

  property p_lpc_allowed;
    o_dec.valid && o_dec.target == LIO_TGT_LPC |-> !(o_dec.is_mem && $past(ctl_q[25])) &&
      !($past(i_cyc.is_io) && !o_dec.is_mem && $past(ctl_q[24]));
  endproperty
  a_lpc_allowed: assert property (p_lpc_allowed) else $error("unclaimed cycle forwarded");

  property p_uart_clash;
    o_dec.valid && (o_dec.target == LIO_TGT_UART1 || o_dec.target == LIO_TGT_UART2) |->
      !$past(u_clash);
  endproperty
  a_uart_clash: assert property (p_uart_clash) else $error("clashing serial bases decoded");
endmodule
`default_nettype wire

//--- lio_pkg.sv
`default_nettype none
package lio_pkg;
  localparam logic [31:0] LIO_CTL_ADDR = 32'h5140_0014;
  localparam logic [31:0] LIO_CTL_RESET = 32'h0400_0003;
  localparam int LIO_SHUT_EN_BIT = 31;
  localparam int LIO_BAD_EN_BIT = 30;
  localparam int LIO_SPEC_MD_BIT = 28;
  localparam int LIO_REMAP_E_BIT = 27;
  localparam int LIO_REMAP_F_BIT = 26;
  localparam int LIO_MEM_DISCARD_BIT = 25;
  localparam int LIO_IO_DISCARD_BIT = 24;
  localparam int LIO_UART2_LSB = 20;
  localparam int LIO_UART1_LSB = 16;
  localparam int LIO_RTC_HI_BIT = 1;
  localparam int LIO_RTC_IDX_BIT = 0;
  localparam int LIO_SSC_SHUT_BIT = 9;
  localparam int LIO_SSC_BAD_BIT = 12;
  localparam logic [7:0] LIO_SC_SHUTDOWN = 8'h00;
  localparam logic [7:0] LIO_SC_HALT_BUS = 8'h01;
  localparam logic [7:0] LIO_SC_HALT_X86 = 8'h02;
  localparam logic [15:0] LIO_SEG_E = 16'h000e;
  localparam logic [15:0] LIO_SEG_F = 16'h000f;
  localparam logic [15:0] LIO_TOP_E = 16'hfffe;
  localparam logic [15:0] LIO_TOP_F = 16'hffff;
  localparam logic [15:0] LIO_PORT_RTC_IDX = 16'h0070;
  localparam logic [15:0] LIO_PORT_RTC_HI = 16'h0072;
  localparam logic [15:0] LIO_BASE_100 = 16'h02e8;
  localparam logic [15:0] LIO_BASE_101 = 16'h02f8;
  localparam logic [15:0] LIO_BASE_110 = 16'h03e8;
  localparam logic [15:0] LIO_BASE_111 = 16'h03f8;
  localparam int LIO_CLK_PS = 5000;
  localparam int LIO_RST_OUT_NS = 100;
  localparam int LIO_RST_OUT_CYC = (LIO_RST_OUT_NS * 1000 + LIO_CLK_PS - 1) / LIO_CLK_PS;

  typedef enum logic [2:0] {
    LIO_TGT_LPC = 3'b000,
    LIO_TGT_ONCHIP = 3'b001,
    LIO_TGT_UART1 = 3'b010,
    LIO_TGT_UART2 = 3'b011,
    LIO_TGT_RTC = 3'b100,
    LIO_TGT_DISCARD = 3'b101,
    LIO_TGT_ERROR = 3'b110,
    LIO_TGT_SPECIAL = 3'b111
  } lio_tgt_e;

  typedef struct packed {
    logic valid;
    logic is_mem;
    logic is_io;
    logic is_special;
    logic write;
    logic dedicated;
    logic claimed;
    logic [31:0] addr;
    logic [7:0] wdata;
  } lio_cyc_s;

  typedef struct packed {
    logic valid;
    logic is_mem;
    lio_tgt_e target;
    logic rd_ones;
    logic [31:0] addr;
  } lio_dec_s;
endpackage
`default_nettype wire
